// *** dfc_pkg.sv ***
// Purpose: constants and types for the debug freeze control block
// Assumes: one 32-bit control word at offset 0x04, plain register port
// Notes:   bit 17 is kept reserved, so there is no timer 7 freeze line
package dfc_pkg;

   localparam logic [31:0] DFC_BASE_ADDR     = 32'hE004_2000;
   localparam logic [7:0]  DFC_CTRL_OFFSET   = 8'h04;
   localparam logic [7:0]  DFC_ID_OFFSET     = 8'h00;
   localparam logic [31:0] DFC_CTRL_RESET    = 32'h0000_0000;
   // arbitrary neutral identity value
   localparam logic [31:0] DFC_ID_VALUE      = 32'h0000_0001;
   // writable bits; reserved 31, 24:22, 17, 7:6, 4:3 read as zero
   localparam logic [31:0] DFC_CTRL_MASK     = 32'h7E3D_FF27;

   // field positions
   localparam int DFC_BIT_SLEEP      = 0;
   localparam int DFC_BIT_DEEPSLEEP  = 1;
   localparam int DFC_BIT_STANDBY    = 2;
   localparam int DFC_BIT_TRACE      = 5;
   localparam int DFC_BIT_FREE_WDG   = 8;
   localparam int DFC_BIT_WIN_WDG    = 9;
   localparam int DFC_BIT_TIMER0     = 10;
   localparam int DFC_BIT_TIMER1     = 11;
   localparam int DFC_BIT_TIMER2     = 12;
   localparam int DFC_BIT_TIMER3     = 13;
   localparam int DFC_BIT_CAN0       = 14;
   localparam int DFC_BIT_SMBUS0     = 15;
   localparam int DFC_BIT_SMBUS1     = 16;
   localparam int DFC_BIT_TIMER4     = 18;
   localparam int DFC_BIT_TIMER5     = 19;
   localparam int DFC_BIT_TIMER6     = 20;
   localparam int DFC_BIT_CAN1       = 21;
   localparam int DFC_BIT_TIMER11    = 25;
   localparam int DFC_BIT_TIMER12    = 26;
   localparam int DFC_BIT_TIMER13    = 27;
   localparam int DFC_BIT_TIMER8     = 28;
   localparam int DFC_BIT_TIMER9     = 29;
   localparam int DFC_BIT_TIMER10    = 30;

   // power modes reported by the power controller
   typedef enum logic [1:0]
   {
      DFC_MODE_RUN       = 2'b00,
      DFC_MODE_SLEEP     = 2'b01,
      DFC_MODE_DEEPSLEEP = 2'b11,
      DFC_MODE_STANDBY   = 2'b10
   } dfc_mode_type;

   // freeze lines to the peripherals
   typedef struct packed
   {
      logic [13:0] timer;        // index = timer number, bit 7 unused
      logic [1:0]  smbus;
      logic [1:0]  can_rx;
      logic        win_wdg;
      logic        free_wdg;
   } dfc_freeze_type;

   // low-power clocking controls
   typedef struct packed
   {
      logic sleep_bus_clock_on;
      logic keep_clock_on_rc;
      logic standby_exit_reset;
      logic trace_pin_allocate;
   } dfc_clock_type;

endpackage : dfc_pkg

// *** dfc_power_watch.sv ***
// Purpose: tracks power mode and raises the standby-exit reset request
// Assumes: power mode input synchronous to clock
// Notes:   request is a one-cycle pulse, registered
`timescale 1ns/100ps
`default_nettype none
module dfc_power_watch
   import dfc_pkg::*;
(
   input  wire logic         clock,        // system clock
   input  wire logic         por_rst,      // power-on reset, async high
   input  wire dfc_mode_type power_mode,   // present power mode
   input  wire logic         standby_keep, // standby clock keep bit
   output logic              exit_reset    // pulse on standby exit
);

   dfc_mode_type last_mode;
   dfc_mode_type next_last_mode;
   logic         next_exit_reset;

   // leaving standby while the keep bit holds asks for a system reset
   always_comb
   begin
      next_last_mode  = power_mode;
      next_exit_reset = standby_keep && (last_mode == DFC_MODE_STANDBY)
                        && (power_mode != DFC_MODE_STANDBY);
   end

   // registers only
   always_ff @(posedge clock or posedge por_rst)
   begin
      if (por_rst)
      begin
         last_mode  <= DFC_MODE_RUN;
         exit_reset <= 1'b0;
      end
      else
      begin
         last_mode  <= next_last_mode;
         exit_reset <= next_exit_reset;
      end
   end

endmodule : dfc_power_watch
`default_nettype wire

// *** dfc_debug_freeze_control.sv ***
// Purpose: debug freeze control register and its peripheral freeze outputs
// Assumes: single clock, plain register port, read data one cycle later
// Notes:   sys_rst is the power-on reset; system reset never touches this block
//
// How it works
// - control word clears to zero only at power-on reset, not system reset.
// - halted core plus bits 10/11/12 freeze timers 0/1/2.
// - halted core plus bits 13/18/19 freeze timers 3/4/5.
// - halted core plus bits 20/28/29 freeze timers 6/8/9.
// - halted core plus bits 30/25/26 freeze timers 10/11/12.
// - halted core plus bit 27 freezes timer 13.
// - halted core plus bits 15/16 freeze SMBus timeouts of I2C 0/1.
// - halted core plus bits 14/21 stop CAN 0/1 receive registers.
// - halted core plus bit 9/8 stops window/free watchdog clocks.
// - bit 5 allocates trace pins to the trace function.
// - bit 2 keeps bus and system clocks on RC oscillator in standby.
// - with bit 2 set, leaving standby requests a system reset.
// - bit 1 keeps bus and system clocks on RC oscillator in deep-sleep.
// - bit 0 keeps the processor bus clock on in sleep.
// - every defined bit reads back what software last wrote.
// - block sits at base 0xE0042000, control word at offset 0x04.
`timescale 1ns/100ps
`default_nettype none
module dfc_debug_freeze_control
   import dfc_pkg::*;
(
   input  wire logic         clock,        // 125 MHz system clock
   input  wire logic         sys_rst,      // power-on reset, async high
   input  wire logic [7:0]   reg_addr,     // byte offset within block
   input  wire logic [31:0]  reg_wdata,    // write data
   input  wire logic         reg_write,    // write strobe
   input  wire logic         reg_read,     // read strobe
   output logic [31:0]       reg_rdata,    // read data, cycle after strobe
   input  wire logic         core_halted,  // processor halted by debugger
   input  wire dfc_mode_type power_mode,   // present power mode
   output dfc_freeze_type    freeze,       // peripheral freeze lines
   output dfc_clock_type     clock_keep    // low-power clock controls
);

   logic [31:0]    debug_freeze_control;
   logic [31:0]    next_debug_freeze_control;
   logic [31:0]    next_reg_rdata;
   dfc_freeze_type next_freeze;
   dfc_clock_type  next_clock_keep;
   logic           standby_exit_pulse;

   // one bit of the control word gated by the halt indication
   function automatic logic halt_gate(input logic [31:0] word, input int pos, input logic halted);
      halt_gate = word[pos] & halted;
   endfunction : halt_gate

   // register write; reserved bits are masked so they always read zero
   always_comb
   begin
      next_debug_freeze_control = debug_freeze_control;
      if (reg_write && (reg_addr == DFC_CTRL_OFFSET))
      begin
         next_debug_freeze_control = reg_wdata & DFC_CTRL_MASK;
      end
   end

   // read path; unmapped offsets return zero
   always_comb
   begin
      next_reg_rdata = 32'h0000_0000;
      if (reg_read)
      begin
         case (reg_addr)
            DFC_CTRL_OFFSET: next_reg_rdata = debug_freeze_control;
            DFC_ID_OFFSET:   next_reg_rdata = DFC_ID_VALUE;
            default:         next_reg_rdata = 32'h0000_0000;
         endcase
      end
   end

   // freeze lines follow halt on the next cycle, so peripherals resume one cycle after the core
   always_comb
   begin
      next_freeze           = '0;
      next_freeze.timer[0]  = halt_gate(debug_freeze_control, DFC_BIT_TIMER0, core_halted);
      next_freeze.timer[1]  = halt_gate(debug_freeze_control, DFC_BIT_TIMER1, core_halted);
      next_freeze.timer[2]  = halt_gate(debug_freeze_control, DFC_BIT_TIMER2, core_halted);
      next_freeze.timer[3]  = halt_gate(debug_freeze_control, DFC_BIT_TIMER3, core_halted);
      next_freeze.timer[4]  = halt_gate(debug_freeze_control, DFC_BIT_TIMER4, core_halted);
      next_freeze.timer[5]  = halt_gate(debug_freeze_control, DFC_BIT_TIMER5, core_halted);
      next_freeze.timer[6]  = halt_gate(debug_freeze_control, DFC_BIT_TIMER6, core_halted);
      next_freeze.timer[8]  = halt_gate(debug_freeze_control, DFC_BIT_TIMER8, core_halted);
      next_freeze.timer[9]  = halt_gate(debug_freeze_control, DFC_BIT_TIMER9, core_halted);
      next_freeze.timer[10] = halt_gate(debug_freeze_control, DFC_BIT_TIMER10, core_halted);
      next_freeze.timer[11] = halt_gate(debug_freeze_control, DFC_BIT_TIMER11, core_halted);
      next_freeze.timer[12] = halt_gate(debug_freeze_control, DFC_BIT_TIMER12, core_halted);
      next_freeze.timer[13] = halt_gate(debug_freeze_control, DFC_BIT_TIMER13, core_halted);
      next_freeze.smbus[0]  = halt_gate(debug_freeze_control, DFC_BIT_SMBUS0, core_halted);
      next_freeze.smbus[1]  = halt_gate(debug_freeze_control, DFC_BIT_SMBUS1, core_halted);
      next_freeze.can_rx[0] = halt_gate(debug_freeze_control, DFC_BIT_CAN0, core_halted);
      next_freeze.can_rx[1] = halt_gate(debug_freeze_control, DFC_BIT_CAN1, core_halted);
      next_freeze.win_wdg   = halt_gate(debug_freeze_control, DFC_BIT_WIN_WDG, core_halted);
      next_freeze.free_wdg  = halt_gate(debug_freeze_control, DFC_BIT_FREE_WDG, core_halted);
   end

   // clock keep controls; the rc source is only asked for in the mode that needs it
   always_comb
   begin
      next_clock_keep                    = '0;
      next_clock_keep.trace_pin_allocate = debug_freeze_control[DFC_BIT_TRACE];
      next_clock_keep.sleep_bus_clock_on = debug_freeze_control[DFC_BIT_SLEEP]
                                           && (power_mode == DFC_MODE_SLEEP);
      next_clock_keep.keep_clock_on_rc   = (debug_freeze_control[DFC_BIT_STANDBY]
                                            && (power_mode == DFC_MODE_STANDBY))
                                           || (debug_freeze_control[DFC_BIT_DEEPSLEEP]
                                            && (power_mode == DFC_MODE_DEEPSLEEP));
      next_clock_keep.standby_exit_reset = standby_exit_pulse;
   end

   // standby exit detection
   dfc_power_watch u_power_watch
   (
      .clock        (clock),
      .por_rst      (sys_rst),
      .power_mode   (power_mode),
      .standby_keep (debug_freeze_control[DFC_BIT_STANDBY]),
      .exit_reset   (standby_exit_pulse)
   );

   // only the power-on reset clears state; system reset is not wired here
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         debug_freeze_control <= DFC_CTRL_RESET;
         reg_rdata            <= 32'h0000_0000;
         freeze               <= '0;
         clock_keep           <= '0;
      end
      else
      begin
         debug_freeze_control <= next_debug_freeze_control;
         reg_rdata            <= next_reg_rdata;
         freeze               <= next_freeze;
         clock_keep           <= next_clock_keep;
      end
   end

endmodule : dfc_debug_freeze_control
`default_nettype wire

// *** dfc_props.sv ***
// Purpose: port checker for debug freeze control
// Assumes: outputs follow their causes one edge later, the exit reset two edges
// Notes:   shadow word mirrors writes to offset 0x04
`timescale 1ns/100ps
`default_nettype none
module dfc_props
   import dfc_pkg::*;
(
   input wire logic           clock,       // clock
   input wire logic           sys_rst,     // por
   input wire logic [7:0]     reg_addr,    // offset
   input wire logic [31:0]    reg_wdata,   // data
   input wire logic           reg_write,   // write
   input wire logic           reg_read,    // read
   input wire logic [31:0]    reg_rdata,   // data
   input wire logic           core_halted, // halt
   input wire dfc_mode_type   power_mode,  // mode
   input wire dfc_freeze_type freeze,      // freezes
   input wire dfc_clock_type  clock_keep   // keeps
);
   logic [31:0] w;
   logic [31:0] next_w;
   logic [2:0]  h;
   logic        rc;
   // shadow word, reserved bits dropped as the block does
   always_comb next_w = (reg_write && reg_addr == 8'h04) ? reg_wdata & DFC_CTRL_MASK : w;
   always_ff @(posedge clock or posedge sys_rst)
      if (sys_rst) w <= '0;
      else w <= next_w;
   // rc keep acts only in its own mode
   assign h = {3{core_halted}};
   assign rc = w[2] && power_mode == DFC_MODE_STANDBY || w[1] && power_mode == DFC_MODE_DEEPSLEEP;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // freezes drop one edge after the core runs again
   a_tmr_low: assert property (freeze.timer[2:0] == $past(w[12:10] & h)) else $error("freeze");
   a_tmr_mid: assert property (freeze.timer[5:3] == $past({w[19:18], w[13]} & h)) else $error("freeze");
   a_tmr_high: assert property ({freeze.timer[9:8], freeze.timer[6]} == $past({w[29:28], w[20]} & h))
      else $error("freeze");
   a_tmr_top: assert property (freeze.timer[13:10] == $past({w[27:25], w[30]} & {h, h[0]}))
      else $error("freeze");
   a_smbus_hold: assert property (freeze.smbus == $past(w[16:15] & h[1:0])) else $error("smbus");
   a_can_hold: assert property (freeze.can_rx == $past({w[21], w[14]} & h[1:0])) else $error("can");
   a_wdg_hold: assert property ({freeze.win_wdg, freeze.free_wdg} == $past(w[9:8] & h[1:0]))
      else $error("watchdog");
   a_trace_pins: assert property (clock_keep.trace_pin_allocate == $past(w[5])) else $error("trace");
   a_rc_keep: assert property (clock_keep.keep_clock_on_rc == $past(rc)) else $error("rc keep");
   a_sleep_keep: assert property (clock_keep.sleep_bus_clock_on == $past(w[0] && power_mode == DFC_MODE_SLEEP))
      else $error("sleep keep");
   a_stb_exit: assert property (w[2] && power_mode == DFC_MODE_STANDBY ##1 w[2] && power_mode != DFC_MODE_STANDBY
      |-> ##[1:3] clock_keep.standby_exit_reset) else $error("exit reset");
   a_read_back: assert property (reg_read && reg_addr == 8'h04 |=> reg_rdata == $past(w)) else $error("read");
   a_por_clear: assert property (disable iff (1'b0) sys_rst |-> reg_rdata == '0 && freeze == '0
      && clock_keep == '0) else $error("reset");
endmodule : dfc_props
bind dfc_debug_freeze_control dfc_props u_props (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_write,
   .reg_read, .reg_rdata, .core_halted, .power_mode, .freeze, .clock_keep);
`default_nettype wire

// *** dfc_core_model.sv ***
// Purpose: core side model, halt level and power mode
// Assumes: bench commands change off the clock edge
// Notes:   levels move only on a clock edge, like a real core
`timescale 1ns/100ps
`default_nettype none
module dfc_core_model
   import dfc_pkg::*;
(
   input  wire logic         clock,       // system clock
   input  wire logic         halt_cmd,    // halt wanted
   input  wire dfc_mode_type mode_cmd,    // mode wanted
   output logic              core_halted, // halt level
   output dfc_mode_type      power_mode   // present mode
);
   // registered so no change lands mid-cycle
   always_ff @(posedge clock)
   begin
      core_halted <= halt_cmd;
      power_mode  <= mode_cmd;
   end
endmodule : dfc_core_model
`default_nettype wire

// *** tb_top.sv ***
// Purpose: random and corner tests of debug freeze control
// Assumes: outputs settle within three edges of a change
// Notes:   exit pulse is predicted from the mode held before each step
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import dfc_pkg::*;
;
   logic           clock, sys_rst, reg_write, reg_read, halt_cmd, core_halted;
   logic [7:0]     reg_addr;
   logic [31:0]    reg_wdata, reg_rdata, w;
   dfc_mode_type   mode_cmd, power_mode;
   dfc_freeze_type freeze;
   dfc_clock_type  clock_keep;
   int             n_errors, cmp_count, k;
   dfc_debug_freeze_control uut (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .core_halted, .power_mode, .freeze, .clock_keep);
   dfc_core_model core (.clock, .halt_cmd, .mode_cmd, .core_halted, .power_mode);
   // 8 ns period
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // expected freezes; p[7] is a reserved bit, always zero
   function automatic dfc_freeze_type exp_frz(logic [31:0] v, logic h);
      int p[14] = '{10, 11, 12, 13, 18, 19, 20, 7, 28, 29, 30, 25, 26, 27};
      dfc_freeze_type f;
      for (int i = 0; i < 14; i++)
         f.timer[i] = v[p[i]] & h;
      f[5:0] = {v[16], v[15], v[21], v[14], v[9], v[8]} & {6{h}};
      return f;
   endfunction : exp_frz
   function automatic dfc_clock_type exp_keep(logic [31:0] v, dfc_mode_type m, logic ex);
      return {v[0] & (m == DFC_MODE_SLEEP), v[2] & (m == DFC_MODE_STANDBY) | v[1] & (m == DFC_MODE_DEEPSLEEP),
              ex, v[5]};
   endfunction : exp_keep
   // every comparison is counted here
   task automatic tally(input logic ok, input string what);
      cmp_count++;
      if (ok !== 1'b1) n_errors++;
      if (ok !== 1'b1) $display("BAD t=%0t %s", $time, what);
   endtask : tally
   task automatic chk_word(input logic [31:0] g, e);
      tally(g === e, "read data");
   endtask : chk_word
   task automatic chk_frz(input dfc_freeze_type g, e);
      tally(g === e, "freeze");
   endtask : chk_frz
   // exit pulse stands exactly at the third edge of a mode step
   task automatic chk_keep(input dfc_clock_type g, e);
      tally(g === e, "clock keep");
   endtask : chk_keep
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clock) reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock) {reg_read, reg_addr} <= {1'b1, a};
      @(posedge clock) reg_read <= 1'b0;
      #1 chk_word(reg_rdata, e);
   endtask : rd
   // core model adds one edge, the block one more, or two for the exit pulse
   task automatic settle(input logic [31:0] v, input logic h, input dfc_mode_type m);
      logic ex;
      // leaving standby with the keep bit set must pulse the exit reset
      ex = v[DFC_BIT_STANDBY] && (mode_cmd == DFC_MODE_STANDBY) && (m != DFC_MODE_STANDBY);
      halt_cmd <= h;
      mode_cmd <= m;
      repeat (3) @(posedge clock);
      #1 chk_frz(freeze, exp_frz(v, h));
      chk_keep(clock_keep, exp_keep(v, m, ex));
   endtask : settle
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict
   // main sequence
   initial
   begin
      {sys_rst, reg_write, reg_read, halt_cmd, reg_addr, reg_wdata} = {4'b1000, 40'h0};
      mode_cmd = DFC_MODE_RUN;
      n_errors = 0;
      cmp_count = 0;
      k = $urandom(32'hf64f_1fbf);
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      rd(8'h04, 32'h0000_0000);
      rd(8'h00, DFC_ID_VALUE);
      rd(8'h08, 32'h0000_0000);
      wr(8'h04, DFC_CTRL_MASK);
      wr(8'h00, 32'h0000_0000);
      rd(8'h04, DFC_CTRL_MASK);
      settle(DFC_CTRL_MASK, 1'b1, DFC_MODE_DEEPSLEEP);
      $display("test corners done");
      repeat (60)
      begin
         w = $urandom() & DFC_CTRL_MASK;
         wr(8'h04, w);
         rd(8'h04, w);
         settle(w, 1'($urandom()), dfc_mode_type'($urandom_range(3, 0)));
      end
      $display("test random done");
      wr(8'h04, 32'h0000_0004);
      settle(32'h0000_0004, 1'b0, DFC_MODE_STANDBY);
      mode_cmd <= DFC_MODE_RUN;
      for (k = 0; k < 6 && clock_keep.standby_exit_reset !== 1'b1; k++)
         @(posedge clock) #1;
      tally(k < 6, "exit reset");
      // a missed pulse skips straight to the verdict
      if (k < 6)
      begin
         $display("test standby done");
         @(posedge clock) sys_rst <= 1'b1;
         @(posedge clock) sys_rst <= 1'b0;
         rd(8'h04, 32'h0000_0000);
         $display("test power reset done");
      end
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
